// [common/lbc_pkg.sv]
// Package for the local bus control sequencer.
// Assumes a single 100 MHz clock and active-low asynchronous reset.
package lbc_pkg;
    localparam int LBC_CLK_NS = 10;
    localparam int LBC_RESET_MIN_NS = 410;
    localparam int LBC_RESET_MIN_CYC = (LBC_RESET_MIN_NS + LBC_CLK_NS - 1) / LBC_CLK_NS;
    localparam int LBC_FIFO_W = 36;
    localparam int LBC_FIFO_D = 8;
    localparam logic [3:0] LBC_BE_NONE = 4'hF;
    localparam logic [1:0] LBC_LEN_ONE = 2'h0;
    localparam int LBC_REQ_W = 40;
    typedef enum logic [4:0] {
        LBC_IDLE = 5'h01,
        LBC_LOCKW = 5'h02,
        LBC_ADDR = 5'h04,
        LBC_DATA = 5'h08,
        LBC_HOLD = 5'h10
    } lbc_state_t;
endpackage

// [hw/lbc_fifo.sv]
// Word FIFO with valid/ready on both sides.
// Assumes one clock domain.
module lbc_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp, rp;
    logic [AW:0] cnt;
    logic wr, rd;
    assign in_ready = (cnt != (AW+1)'(DEPTH));
    assign out_valid = (cnt != '0);
    assign out_data = mem[rp];
    assign wr = in_valid && in_ready;
    assign rd = out_valid && out_ready;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (wr) wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
            if (rd) rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
            cnt <= cnt + (AW+1)'(wr) - (AW+1)'(rd);
        end
    end
    always_ff @(posedge clk) begin
        if (wr) mem[wp] <= in_data;
    end
endmodule

// [hw/lbc_ctrl.sv]
// Local bus control sequencer: strobes, lock, byte lanes, hold, error.
// Assumes a requesting core on the same clock; bus pins are asynchronous.
import lbc_pkg::*;

// Contract
// [R1] Transceiver enable low in every data and wait state.
// [R2] Missing ready in a data state adds a wait state until seen.
// [R3] Address strobe stays inactive after a data state without ready.
// [R4] Locked operation waits while another agent holds lock.
// [R5] Lock driven active in address state of the locked read.
// [R6] Lock released in address state of the locked write.
// [R7] Others may read or write under lock, not start locked operations.
// [R8] Lock held active through interrupt-acknowledge transactions.
// [R9] Four active-low byte lanes, top lane bits 31:24, bottom 7:0.
// [R10] Address state lanes describe the first data word.
// [R11] Data state lanes describe the next word, if any.
// [R12] Lanes registered, held steady while ready is inactive.
// [R13] Read lanes name exactly the bytes consumed.
// [R14] Active lanes are contiguous with at least one active.
// [R15] Bus request accepted: float outputs, grant hold, enter hold state.
// [R16] Request withdrawn: drop grant, go idle or address state.
// [R17] Cacheable driven in address state, never for synchronous access.
// [R18] Cacheable floats while the bus is idle.
// [R19] Bus error after final ready marks the transaction failed.
// [R20] Bus error sampled during reset as boot strap.
// [R21] In reset ignore inputs, float three-state, others inactive; strobe, enable and lanes are driven inactive instead.
// [R22] Reset held at least 41 double-rate clock cycles.
// [R23] Burst re-asserts address strobe after a ready cycle.
// [R24] Burst length coded on low bits as words minus one.
// [R25] After final ready with nothing pending, return to idle.
module lbc_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    // Core request side: {lock_rmw_read, lock_rmw_write/sync, iack, cacheable, len[1:0], be[3:0], addr[29:0]}
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [lbc_pkg::LBC_REQ_W-1:0] req_data,
    output logic done,
    output logic failed,
    output logic boot_master,
    // Bus pins
    input wire logic ready_n,
    input wire logic hold,
    input wire logic bus_error_in_n,
    input wire logic lock_n_in,
    output logic lock_n_out,
    output logic lock_n_oe_n,
    output logic address_strobe_n,
    output logic address_strobe_oe_n,
    output logic transceiver_enable_n,
    output logic transceiver_enable_oe_n,
    output logic [3:0] byte_lane_enables,
    output logic byte_lanes_oe_n,
    output logic [31:0] addr_out,
    output logic addr_oe_n,
    output logic hold_grant,
    output logic hold_grant_oe_n,
    output logic cacheable,
    output logic cacheable_oe_n
);
    import lbc_pkg::*;

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [3:0] s1, s2;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= 4'hF;
            s2 <= 4'hF;
        end else begin
            s1 <= {ready_n, ~hold, bus_error_in_n, lock_n_in};
            s2 <= s1;
        end
    end
    logic rdy, hld, berr, lock_busy;
    assign rdy = ~s2[3];
    assign hld = ~s2[2];
    assign berr = ~s2[1];
    assign lock_busy = ~s2[0];

    // ****************************************
    // Boot strap
    // ****************************************
    // Own pair without reset, so the pin is still sampled while reset is held
    logic strap_s1, strap_s2;
    always_ff @(posedge clk) begin
        strap_s1 <= bus_error_in_n;
        strap_s2 <= strap_s1;
    end

    // ****************************************
    // Request FIFO
    // ****************************************
    logic q_valid, q_take;
    logic [LBC_FIFO_W-1:0] q_data;
    lbc_fifo #(.WIDTH(LBC_FIFO_W), .DEPTH(LBC_FIFO_D)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data(req_data[LBC_FIFO_W-1:0]),
        .out_valid(q_valid),
        .out_ready(q_take),
        .out_data(q_data)
    );
    // FIFO carries addr/be/len; flags are held beside the head entry
    logic [3:0] head_flags;
    logic [3:0] flag_mem [LBC_FIFO_D];
    logic [2:0] fw, fr;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fw <= 3'h0;
            fr <= 3'h0;
        end else begin
            if (req_valid && req_ready) fw <= fw + 3'h1;
            if (q_take) fr <= fr + 3'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (req_valid && req_ready) flag_mem[fw] <= req_data[LBC_REQ_W-1:LBC_FIFO_W];
    end
    assign head_flags = flag_mem[fr];

    // ****************************************
    // Sequencer state
    // ****************************************
    typedef struct packed {
        lbc_state_t st;
        logic strobe;
        logic locked;
        logic [1:0] left;
        logic [3:0] be;
        logic [29:0] addr;
        logic iack;
        logic wr_half;
        logic cache;
        logic check_err;
        logic done;
        logic failed;
        logic boot;
        logic boot_taken;
    } lbc_ctrl_t;
    lbc_ctrl_t r, next_r;

    logic rmw_start;
    assign rmw_start = head_flags[3];

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.failed = 1'b0;
        next_r.check_err = 1'b0;
        next_r.strobe = 1'b0;
        q_take = 1'b0;
        if (!r.boot_taken) begin
            next_r.boot = strap_s2; // R20
            next_r.boot_taken = 1'b1;
        end
        if (r.check_err) begin
            next_r.done = 1'b1;
            next_r.failed = berr; // R19
        end
        case (r.st)
            LBC_IDLE, LBC_LOCKW: begin
                if (hld && !r.locked) begin
                    next_r.st = LBC_HOLD; // R15
                end else if (q_valid) begin
                    if (rmw_start && !r.locked && lock_busy) begin
                        next_r.st = LBC_LOCKW; // R4
                    end else begin
                        q_take = 1'b1;
                        next_r.st = LBC_ADDR;
                        next_r.strobe = 1'b1;
                        next_r.addr = q_data[29:0];
                        next_r.be = (q_data[33:30] == LBC_BE_NONE) ? 4'hE : q_data[33:30]; // R14
                        next_r.left = q_data[35:34];
                        next_r.iack = head_flags[1];
                        next_r.cache = head_flags[0] && !head_flags[2]; // R17
                        next_r.wr_half = head_flags[2] && !head_flags[3];
                        if (head_flags[3] || head_flags[1]) next_r.locked = 1'b1; // R5 R8
                        if (r.locked && !head_flags[3]) next_r.locked = 1'b0; // R6
                    end
                end else begin
                    next_r.st = LBC_IDLE; // R25
                end
            end
            LBC_ADDR: begin
                next_r.st = LBC_DATA; // R10
            end
            LBC_DATA: begin
                if (rdy) begin
                    if (r.left == LBC_LEN_ONE) begin
                        next_r.check_err = 1'b1;
                        if (r.iack) next_r.locked = 1'b0; // R8
                        next_r.st = LBC_IDLE; // R25
                    end else begin
                        next_r.left = r.left - 2'h1;
                        next_r.strobe = 1'b1; // R23
                    end
                end
                // Without ready the lanes and state hold: wait state R2 R3 R12
            end
            LBC_HOLD: begin
                if (!hld) next_r.st = LBC_IDLE; // R16
            end
            default: next_r.st = LBC_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{st: LBC_IDLE, be: LBC_BE_NONE, default: '0}; // R21
        end else begin
            r <= next_r;
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    logic active;
    assign active = (r.st == LBC_ADDR) || (r.st == LBC_DATA);
    assign address_strobe_n = ~((r.st == LBC_ADDR) || (r.st == LBC_DATA && r.strobe)); // R3 R23
    assign address_strobe_oe_n = (r.st == LBC_HOLD); // R15
    assign transceiver_enable_n = ~(r.st == LBC_DATA); // R1
    assign transceiver_enable_oe_n = (r.st == LBC_HOLD);
    assign byte_lane_enables = active ? r.be : LBC_BE_NONE; // R9 R11 R13
    assign byte_lanes_oe_n = (r.st == LBC_HOLD);
    assign addr_out = (r.st == LBC_ADDR) ? {r.addr, r.left} : 32'h0; // R24
    assign addr_oe_n = ~active;
    assign lock_n_out = ~r.locked;
    assign lock_n_oe_n = ~r.locked; // R6
    assign hold_grant = (r.st == LBC_HOLD); // R15 R16
    assign hold_grant_oe_n = ~r.boot_taken; // R21
    assign cacheable = r.cache;
    assign cacheable_oe_n = ~(r.st == LBC_ADDR); // R18
    assign done = r.done;
    assign failed = r.failed;
    assign boot_master = r.boot;

    // ****************************************
    // Lane shape
    // ****************************************
    // Active lanes must form one run without gaps
    logic lanes_contig;
    always_comb begin
        case (~byte_lane_enables)
            4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hC, 4'h7, 4'hE, 4'hF: lanes_contig = 1'b1;
            default: lanes_contig = 1'b0;
        endcase
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_den;
        @(posedge clk) disable iff (!rst_n) (r.st == LBC_DATA) |-> !transceiver_enable_n;
    endproperty
    a_den: assert property (p_den) else $error("transceiver enable idle in data state"); // R1
    property p_wait;
        @(posedge clk) disable iff (!rst_n) (r.st == LBC_DATA && !rdy) |=> (r.st == LBC_DATA);
    endproperty
    a_wait: assert property (p_wait) else $error("data state left without ready"); // R2
    property p_nostrobe;
        @(posedge clk) disable iff (!rst_n) (r.st == LBC_DATA && !rdy) |=> address_strobe_n;
    endproperty
    a_nostrobe: assert property (p_nostrobe) else $error("strobe after wait"); // R3
    property p_be_hold;
        @(posedge clk) disable iff (!rst_n) (r.st == LBC_DATA && !rdy) |=> $stable(byte_lane_enables);
    endproperty
    a_be_hold: assert property (p_be_hold) else $error("lanes changed in wait"); // R12
    property p_be_any;
        @(posedge clk) disable iff (!rst_n) active |-> (byte_lane_enables != LBC_BE_NONE);
    endproperty
    a_be_any: assert property (p_be_any) else $error("no lane active"); // R14
    property p_hold;
        @(posedge clk) disable iff (!rst_n) hold_grant |-> (address_strobe_oe_n && byte_lanes_oe_n);
    endproperty
    a_hold: assert property (p_hold) else $error("driving during hold"); // R15
    property p_release;
        @(posedge clk) disable iff (!rst_n) (hold_grant && !hld) |=> !hold_grant;
    endproperty
    a_release: assert property (p_release) else $error("grant kept after request gone"); // R16
    property p_cache_float;
        @(posedge clk) disable iff (!rst_n) (r.st == LBC_IDLE) |-> cacheable_oe_n;
    endproperty
    a_cache_float: assert property (p_cache_float) else $error("cacheable driven when idle"); // R18
    sequence s_last_ready;
        (r.st == LBC_DATA) && rdy && (r.left == LBC_LEN_ONE);
    endsequence
    property p_err;
        @(posedge clk) disable iff (!rst_n) s_last_ready ##1 berr |=> failed;
    endproperty
    a_err: assert property (p_err) else $error("bus error not reported"); // R19
    property p_idle_return;
        @(posedge clk) disable iff (!rst_n) s_last_ready |=> (r.st == LBC_IDLE);
    endproperty
    a_idle_return: assert property (p_idle_return) else $error("sequencer not idle after last ready"); // R25

    // ****************************************
    // Lock, burst, lane and cacheable checks
    // ****************************************
    sequence s_take_rmw_read;
        q_take && rmw_start;
    endsequence
    property p_lock_read;
        @(posedge clk) disable iff (!rst_n) s_take_rmw_read |=> (!lock_n_oe_n && !lock_n_out);
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock not driven for locked read"); // R5
    property p_lock_write;
        @(posedge clk) disable iff (!rst_n)
            (q_take && r.locked && !rmw_start && !head_flags[1]) |=> lock_n_oe_n;
    endproperty
    a_lock_write: assert property (p_lock_write) else $error("lock kept at locked write"); // R6
    property p_lock_wait;
        @(posedge clk) disable iff (!rst_n)
            ((r.st == LBC_IDLE || r.st == LBC_LOCKW) && q_valid && rmw_start && !r.locked && lock_busy) |=> address_strobe_n;
    endproperty
    a_lock_wait: assert property (p_lock_wait) else $error("locked read started on busy lock"); // R4
    sequence s_iack_data;
        (r.st == LBC_DATA) && r.iack;
    endsequence
    property p_iack_lock;
        @(posedge clk) disable iff (!rst_n) s_iack_data |-> !lock_n_oe_n;
    endproperty
    a_iack_lock: assert property (p_iack_lock) else $error("lock free during acknowledge"); // R8
    property p_burst;
        @(posedge clk) disable iff (!rst_n)
            ((r.st == LBC_DATA) && rdy && (r.left != LBC_LEN_ONE)) |=> !address_strobe_n;
    endproperty
    a_burst: assert property (p_burst) else $error("burst strobe missing"); // R23
    property p_be_first;
        @(posedge clk) disable iff (!rst_n)
            (q_take && (q_data[33:30] != LBC_BE_NONE)) |=> (byte_lane_enables == $past(q_data[33:30]));
    endproperty
    a_be_first: assert property (p_be_first) else $error("address state lanes wrong"); // R10
    property p_contig;
        @(posedge clk) disable iff (!rst_n) active |-> lanes_contig;
    endproperty
    a_contig: assert property (p_contig) else $error("lanes have a gap"); // R14
    property p_sync_nocache;
        @(posedge clk) disable iff (!rst_n) (q_take && head_flags[2]) |=> !cacheable;
    endproperty
    a_sync_nocache: assert property (p_sync_nocache) else $error("cacheable on synchronous access"); // R17
endmodule

// [dv/lbc_bus_model.sv]
// Far-side bus model: answers each transaction with ready pulses and an optional error.
// Assumes burst size on addr_out[1:0] while the strobe is low outside data states.
module lbc_bus_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic address_strobe_n,
    input wire logic transceiver_enable_n,
    input wire logic [1:0] size,
    input wire logic [3:0] wait_cyc,
    input wire logic err,
    output logic ready_n,
    output logic bus_error_in_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] words;
    logic [3:0] wt;
    logic fin;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            words <= 3'h0;
            wt <= 4'h0;
            fin <= 1'b0;
            ready_n <= 1'b1;
            bus_error_in_n <= 1'b1;
        end else begin
            ready_n <= 1'b1;
            bus_error_in_n <= ~(fin & err);
            fin <= 1'b0;
            if (words == 3'h0 && !address_strobe_n && transceiver_enable_n) begin
                words <= {1'b0, size} + 3'h1;
                wt <= wait_cyc;
            end else if (words != 3'h0) begin
                if (wt != 4'h0) begin
                    wt <= wt - 4'h1;
                end else begin
                    ready_n <= 1'b0;
                    wt <= wait_cyc;
                    words <= words - 3'h1;
                    fin <= (words == 3'h1);
                end
            end
        end
    end
endmodule

// [dv/local_bus_control_signals_tb.sv]
// Self-checking bench for the local bus control sequencer.
// Assumes a pulled-up lock line shared with another agent.
module local_bus_control_signals_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lbc_pkg::*;
    typedef struct packed {logic [1:0] l; logic [3:0] b; logic c; logic s; logic [3:0] w; logic e;} lbc_row_t;
    logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, hold = 1'b0, oth_lock_n = 1'b1, err = 1'b0;
    logic [39:0] req_data = 40'h0;
    logic [3:0] wait_cyc = 4'h0;
    logic req_ready, done, failed, boot_master, ready_n, bus_error_in_n, lock_n_out, lock_n_oe_n;
    logic address_strobe_n, address_strobe_oe_n, transceiver_enable_n, transceiver_enable_oe_n;
    logic [3:0] byte_lane_enables;
    logic byte_lanes_oe_n, addr_oe_n, hold_grant, hold_grant_oe_n, cacheable, cacheable_oe_n;
    logic [31:0] addr_out;
    wire logic lock_line = oth_lock_n & (lock_n_oe_n | lock_n_out);
    int bad_count = 0, checked = 0;
    lbc_row_t rows [5] = '{'{2'h0, 4'hE, 1'h1, 1'h0, 4'h0, 1'h0}, '{2'h1, 4'h0, 1'h0, 1'h0, 4'h2, 1'h0},
        '{2'h3, 4'hC, 1'h1, 1'h1, 4'h0, 1'h0}, '{2'h2, 4'h9, 1'h1, 1'h0, 4'h1, 1'h1},
        '{2'h0, 4'h7, 1'h0, 1'h0, 4'h3, 1'h0}};
    lbc_ctrl dut (.*, .lock_n_in(lock_line));
    lbc_bus_model bm (.clk(clk), .rst_n(rst_n), .address_strobe_n(address_strobe_n),
        .transceiver_enable_n(transceiver_enable_n), .size(addr_out[1:0]), .wait_cyc(wait_cyc),
        .err(err), .ready_n(ready_n), .bus_error_in_n(bus_error_in_n));
    // ****************
    // Tasks
    // ****************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (e !== g) begin
            $display("[ERR] %s exp %0h got %0h", nm, e, g);
            bad_count++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_for(input string nm, ref logic s, input logic lv);
        int n;
        n = 0;
        while (s !== lv && n < 60) begin
            tick(1);
            n++;
        end
        if (n == 60) chk(nm, lv, s);
    endtask
    task automatic send(input logic [2:0] f, input logic c, input logic [1:0] l, input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_data <= {f, c, l, b, 30'h0000100};
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 40);
        req_valid <= 1'b0;
    endtask
    task automatic test_done;
        $display("TB: checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ****************
    // Tests
    // ****************
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #100us;
        bad_count++;
        test_done;
    end
    initial begin
        tick(10);
        chk("rst_lanes", 4'hF, byte_lane_enables);
        chk("rst_grant", 1'h0, hold_grant);
        chk("rst_cache_float", 1'h1, cacheable_oe_n);
        chk("rst_grant_float", 1'h1, hold_grant_oe_n);
        chk("rst_enable", 1'h1, transceiver_enable_n);
        repeat (LBC_RESET_MIN_CYC) @(posedge clk);
        rst_n <= 1'b1;
        tick(2);
        chk("boot", 1'h1, boot_master);
        $display("TB: reset test done");
        foreach (rows[i]) begin
            wait_cyc = rows[i].w;
            err = rows[i].e;
            send({1'b0, rows[i].s, 1'b0}, rows[i].c, rows[i].l, rows[i].b);
            wait_for("strobe", address_strobe_n, 1'b0);
            chk("lanes", rows[i].b, byte_lane_enables);
            chk("size", rows[i].l, addr_out[1:0]);
            chk("addr", 30'h0000100, addr_out[31:2]);
            chk("cache", rows[i].c & ~rows[i].s, cacheable);
            tick(1);
            chk("enable", 1'h0, transceiver_enable_n);
            wait_for("done", done, 1'b1);
            chk("failed", rows[i].e, failed);
            tick(1);
            chk("idle_cache_float", 1'h1, cacheable_oe_n);
            $display("TB: row %0d done", i);
        end
        err = 1'b0;
        @(posedge clk);
        oth_lock_n <= 1'b0;
        send(3'h4, 1'h0, 2'h0, 4'hE);
        repeat (20) begin
            tick(1);
            chk("lock_wait", 1'h1, address_strobe_n);
        end
        @(posedge clk);
        oth_lock_n <= 1'b1;
        wait_for("strobe", address_strobe_n, 1'b0);
        chk("lock_on", 1'h0, lock_n_oe_n);
        chk("lock_drive", 1'h0, lock_n_out);
        wait_for("done", done, 1'b1);
        send(3'h2, 1'h0, 2'h0, 4'hE);
        wait_for("strobe", address_strobe_n, 1'b0);
        chk("lock_off", 1'h1, lock_n_oe_n);
        wait_for("done", done, 1'b1);
        send(3'h1, 1'h0, 2'h0, 4'hE);
        wait_for("strobe", address_strobe_n, 1'b0);
        chk("iack_lock", 1'h0, lock_n_oe_n);
        wait_for("done", done, 1'b1);
        $display("TB: lock test done");
        @(posedge clk);
        hold <= 1'b1;
        wait_for("grant", hold_grant, 1'b1);
        chk("hold_float", 1'h1, addr_oe_n & address_strobe_oe_n & cacheable_oe_n);
        chk("hold_float_od", 1'h1, transceiver_enable_oe_n & byte_lanes_oe_n & lock_n_oe_n);
        chk("grant_drive", 1'h0, hold_grant_oe_n);
        repeat (8) send(3'h0, 1'h0, 2'h0, 4'hE);
        tick(1);
        chk("fifo_full", 1'h0, req_ready);
        @(posedge clk);
        hold <= 1'b0;
        wait_for("release", hold_grant, 1'b0);
        chk("grant_off", 1'h0, hold_grant);
        repeat (8) begin
            wait_for("drain", done, 1'b1);
            tick(1);
        end
        chk("fifo_empty", 1'h1, req_ready);
        $display("TB: hold and buffer test done");
        wait_cyc = 4'h5;
        send(3'h0, 1'h0, 2'h3, 4'h0);
        wait_for("strobe", address_strobe_n, 1'b0);
        @(posedge clk);
        rst_n <= 1'b0;
        tick(2);
        chk("mid_rst_enable", 1'h1, transceiver_enable_n);
        chk("mid_rst_addr_float", 1'h1, addr_oe_n);
        chk("mid_rst_lanes", 4'hF, byte_lane_enables);
        chk("mid_rst_grant_float", 1'h1, hold_grant_oe_n);
        repeat (LBC_RESET_MIN_CYC) @(posedge clk);
        rst_n <= 1'b1;
        tick(2);
        chk("mid_boot", 1'h1, boot_master);
        chk("mid_strobe", 1'h1, address_strobe_n);
        chk("mid_fifo_empty", 1'h1, req_ready);
        $display("TB: mid-run reset test done");
        test_done;
    end
endmodule
